/* File: psstat_pkg.sv */
// Purpose: Shared constants and types for the power state status register.
// Assumes: Core clock of 200 MHz; 16-bit register image.
// Notes:   Field positions, reset values and timing counts are named here once.
package psstat_pkg;

    // Power state encodings as reported in the two-bit state field.
    typedef enum logic [1:0] {
        PSSTAT_ACTIVE    = 2'h0,
        PSSTAT_VCC_STBY  = 2'h1,
        PSSTAT_BAT_STBY  = 2'h2,
        PSSTAT_FLASH     = 2'h3
    } psstat_state_t;

    // Field positions inside the status word.
    localparam int WD_FAIL_LSB   = 12;
    localparam int WD_FAIL_MSB   = 15;
    localparam int FORCED_WD_BIT = 11;
    localparam int FORCED_OT_BIT = 10;
    localparam int STATE_LSB     = 8;
    localparam int STATE_MSB     = 9;
    localparam int RETRY_LSB     = 4;
    localparam int RETRY_MSB     = 6;
    localparam int SETTLE_BIT    = 3;

    // Reset values.
    localparam logic [3:0]  WD_FAIL_RST = 4'h0;
    localparam logic [2:0]  RETRY_RST   = 3'h0;
    localparam logic        SETTLE_RST  = 1'b1;
    localparam logic [1:0]  STATE_RST   = 2'h2;
    localparam logic        FORCED_RST  = 1'b0;
    localparam logic        HOLD_RST    = 1'b0;

    // Settling interval after wake-up, in nanoseconds, and its cycle count.
    localparam int CLK_PERIOD_NS   = 5;
    localparam int SETTLE_TIME_NS  = 200000;
    localparam int SETTLE_CYCLES   = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_CNT_W    = 16;

endpackage : psstat_pkg

/* File: psstat_settle.sv */
// Purpose: Counts the settling interval after a wake from logic-supply standby into active.
// Assumes: START is a one-cycle pulse on the core clock.
// Notes:   The interval length is a parameter so simulation can shorten it.
module psstat_settle #(
    parameter int SETTLE_CYCLES = psstat_pkg::SETTLE_CYCLES
) (
    input  wire logic CORE_CLK,
    input  wire logic RST_B,
    input  wire logic CLK_EN,
    input  wire logic START,
    output logic      BUSY
);

    logic [psstat_pkg::SETTLE_CNT_W-1:0] cnt_r;

    // Loads the count on start and runs it down to zero; busy while nonzero.
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            cnt_r <= '0;
        end else if (CLK_EN) begin
            if (START) begin
                cnt_r <= SETTLE_CYCLES[psstat_pkg::SETTLE_CNT_W-1:0];
            end else if (cnt_r != '0) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end

    assign BUSY = (cnt_r != '0);

endmodule : psstat_settle

/* File: psstat_reg.sv */
// Purpose: Power state status register with watchdog, overheat and settling fields.
// Assumes: All event inputs are one-cycle pulses from logic on CORE_CLK.
// Notes:   The register is read through the serial control port's read strobes.
// Functional notes
// - The four-bit watchdog failure count is kept and a read-and-clear leaves it untouched.
// - The failure count clears on a proper watchdog trigger or a watchdog-forced standby.
// - Separate sticky flags record standby forced by watchdog and by overheat until read-and-clear.
// - The state field encodes 00 active, 01 logic standby, 10 battery standby or reset, 11 flash.
// - The state field updates on every state transition and on each read-and-clear.
// - The first read after entering active or flash returns the previous state.
// - After a read-and-clear later reads return the state currently in force.
// - The settling flag stands for 200 us after logic standby to active and gates all drivers.
// - The settling flag clears itself and ignores read-and-clear.
// - A read-and-clear resets all latched fields except the watchdog and settling bits.
// - Fields sit at 15:12, 11, 10, 9:8, 6:4 and 3; other bits read zero.
module psstat_reg #(
    parameter int SETTLE_CYCLES = psstat_pkg::SETTLE_CYCLES
) (
    input  wire logic        CORE_CLK,
    input  wire logic        RST_B,
    input  wire logic        CLK_EN,
    input  wire logic        RD_STB,
    input  wire logic        RD_CLR_STB,
    input  wire logic        WD_FAIL_EVT,
    input  wire logic        WD_OK_EVT,
    input  wire logic        WD_FORCE_EVT,
    input  wire logic        OT_FORCE_EVT,
    input  wire logic        OT_RETRY_EVT,
    input  wire logic        STATE_CHG_EVT,
    input  wire logic [1:0]  NEW_STATE,
    output logic      [15:0] RD_DATA,
    output logic             RD_VALID,
    output logic             DRV_DISABLE
);

    logic [3:0] wd_fail_r;
    logic       forced_wd_r;
    logic       forced_ot_r;
    logic [1:0] shown_state_r;
    logic [1:0] cur_state_r;
    logic       hold_prev_r;
    logic [2:0] retry_r;
    logic       settle_start;
    logic       settle_busy;
    logic       rd_any;

    // Builds the status word from the held fields.
    function automatic logic [15:0] pack_word(input logic [3:0] wdf, input logic fwd,
                                              input logic fot, input logic [1:0] st,
                                              input logic [2:0] rt, input logic nr);
        logic [15:0] w;
        w = '0;
        w[psstat_pkg::WD_FAIL_MSB:psstat_pkg::WD_FAIL_LSB] = wdf;
        w[psstat_pkg::FORCED_WD_BIT] = fwd;
        w[psstat_pkg::FORCED_OT_BIT] = fot;
        w[psstat_pkg::STATE_MSB:psstat_pkg::STATE_LSB] = st;
        w[psstat_pkg::RETRY_MSB:psstat_pkg::RETRY_LSB] = rt;
        w[psstat_pkg::SETTLE_BIT] = nr;
        return w;
    endfunction : pack_word

    // Saturating step of the watchdog failure count; it sticks at all ones.
    function automatic logic [3:0] wd_fail_step(input logic [3:0] cnt);
        return (cnt == 4'hf) ? cnt : cnt + 4'h1;
    endfunction : wd_fail_step

    // Saturating step of the overheat restart count; it sticks at all ones.
    function automatic logic [2:0] retry_step(input logic [2:0] cnt);
        return (cnt == 3'h7) ? cnt : cnt + 3'h1;
    endfunction : retry_step

    // True for the target states whose first read reports the state left behind.
    function automatic logic shows_previous(input logic [1:0] st);
        return (st == psstat_pkg::PSSTAT_ACTIVE) || (st == psstat_pkg::PSSTAT_FLASH);
    endfunction : shows_previous

    // True for the transition from logic-supply standby into active mode.
    function automatic logic wakes_to_active(input logic [1:0] from_st, input logic [1:0] to_st);
        return (from_st == psstat_pkg::PSSTAT_VCC_STBY) && (to_st == psstat_pkg::PSSTAT_ACTIVE);
    endfunction : wakes_to_active

    assign rd_any = RD_STB | RD_CLR_STB;

    // A wake from logic standby into active arms the settling interval.
    assign settle_start = STATE_CHG_EVT && wakes_to_active(cur_state_r, NEW_STATE);

    psstat_settle #(
        .SETTLE_CYCLES (SETTLE_CYCLES)
    ) u_settle (
        .CORE_CLK (CORE_CLK),
        .RST_B    (RST_B),
        .CLK_EN   (CLK_EN),
        .START    (settle_start),
        .BUSY     (settle_busy)
    );

    // Watchdog failure count; clear events win over a failure, read-and-clear is ignored.
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            wd_fail_r <= psstat_pkg::WD_FAIL_RST;
        end else if (CLK_EN) begin
            if (WD_OK_EVT || WD_FORCE_EVT) begin
                wd_fail_r <= psstat_pkg::WD_FAIL_RST;
            end else if (WD_FAIL_EVT) begin
                wd_fail_r <= wd_fail_step(wd_fail_r);
            end
        end
    end

    // Sticky watchdog-forced standby flag; a new event wins over a clear in the same cycle.
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            forced_wd_r <= psstat_pkg::FORCED_RST;
        end else if (CLK_EN) begin
            if (WD_FORCE_EVT) begin
                forced_wd_r <= 1'b1;
            end else if (RD_CLR_STB) begin
                forced_wd_r <= psstat_pkg::FORCED_RST;
            end
        end
    end

    // Sticky overheat-forced standby flag, with the same set-over-clear priority.
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            forced_ot_r <= psstat_pkg::FORCED_RST;
        end else if (CLK_EN) begin
            if (OT_FORCE_EVT) begin
                forced_ot_r <= 1'b1;
            end else if (RD_CLR_STB) begin
                forced_ot_r <= psstat_pkg::FORCED_RST;
            end
        end
    end

    // Overheat restart count, saturating, cleared by read-and-clear unless an attempt lands.
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            retry_r <= psstat_pkg::RETRY_RST;
        end else if (CLK_EN) begin
            if (RD_CLR_STB) begin
                retry_r <= OT_RETRY_EVT ? 3'h1 : psstat_pkg::RETRY_RST;
            end else if (OT_RETRY_EVT) begin
                retry_r <= retry_step(retry_r);
            end
        end
    end

    // Live device state, following every transition.
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            cur_state_r <= psstat_pkg::STATE_RST;
        end else if (CLK_EN) begin
            if (STATE_CHG_EVT) begin
                cur_state_r <= NEW_STATE;
            end
        end
    end

    // Marks that the shown field still holds the state left when entering active or flash.
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            hold_prev_r <= psstat_pkg::HOLD_RST;
        end else if (CLK_EN) begin
            if (STATE_CHG_EVT) begin
                hold_prev_r <= shows_previous(NEW_STATE);
            end else if (rd_any) begin
                hold_prev_r <= psstat_pkg::HOLD_RST;
            end
        end
    end

    // State shown to software; a held previous state is released by the first read.
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            shown_state_r <= psstat_pkg::STATE_RST;
        end else if (CLK_EN) begin
            if (STATE_CHG_EVT) begin
                if (shows_previous(NEW_STATE)) begin
                    shown_state_r <= cur_state_r;
                end else begin
                    shown_state_r <= NEW_STATE;
                end
            end else if (RD_CLR_STB || (RD_STB && hold_prev_r)) begin
                shown_state_r <= cur_state_r;
            end
        end
    end

    // Answer strobe: one cycle high after every taken read of either kind.
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            RD_VALID <= 1'b0;
        end else if (CLK_EN) begin
            RD_VALID <= rd_any;
        end
    end

    // Read data register: captures the word before any clear takes effect.
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            RD_DATA <= '0;
        end else if (CLK_EN) begin
            if (rd_any) begin
                RD_DATA <= pack_word(wd_fail_r, forced_wd_r, forced_ot_r,
                                     shown_state_r, retry_r, settle_busy);
            end
        end
    end

    // Output drivers are held off while the settling flag stands.
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            DRV_DISABLE <= psstat_pkg::SETTLE_RST;
        end else if (CLK_EN) begin
            DRV_DISABLE <= settle_busy | settle_start;
        end
    end

endmodule : psstat_reg

/* File: psstat_host.sv */
// Purpose: Host side model that issues status reads to the register.
// Assumes: Requests arrive as one-cycle pulses on the core clock.
// Notes:   Strobes follow the requests with no added delay.
module psstat_host (
    input  wire logic req_rd,
    input  wire logic req_clr,
    output logic      rd_stb,
    output logic      rd_clr_stb
);
    // Plain reads and read-and-clear accesses pass straight to the port.
    assign rd_stb     = req_rd;
    assign rd_clr_stb = req_clr;
endmodule : psstat_host

/* File: psstat_reg_props.sv */
// Purpose: Port assertions for the power state status register.
// Assumes: One clock domain, RST_B low resets.
// Notes:   Bound to every instance of the register.
module psstat_reg_chk #(
    parameter int SETTLE_CYCLES = psstat_pkg::SETTLE_CYCLES
) (
    input wire logic        CORE_CLK,
    input wire logic        RST_B,
    input wire logic        CLK_EN,
    input wire logic        RD_STB,
    input wire logic        RD_CLR_STB,
    input wire logic        WD_FAIL_EVT,
    input wire logic        WD_OK_EVT,
    input wire logic        WD_FORCE_EVT,
    input wire logic        OT_FORCE_EVT,
    input wire logic        OT_RETRY_EVT,
    input wire logic        STATE_CHG_EVT,
    input wire logic [1:0]  NEW_STATE,
    input wire logic [15:0] RD_DATA,
    input wire logic        RD_VALID,
    input wire logic        DRV_DISABLE
);
    // A taken read, and a cycle with no watchdog event.
    logic tk;
    logic wq;
    assign tk = CLK_EN && (RD_STB || RD_CLR_STB);
    assign wq = !(WD_FAIL_EVT || WD_OK_EVT || WD_FORCE_EVT);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);
    read_answer_a: assert property (tk |=> RD_VALID)
        else $error("read strobe got no answer");
    valid_pulse_a: assert property (CLK_EN && !tk |=> !RD_VALID)
        else $error("answer without read strobe");
    spare_zero_a: assert property (RD_VALID |-> RD_DATA[7] == 1'h0 && RD_DATA[2:0] == 3'h0)
        else $error("unused bits not zero");
    settle_cause_a: assert property ($rose(DRV_DISABLE) |-> $past(STATE_CHG_EVT && CLK_EN && NEW_STATE == 2'h0))
        else $error("drivers disabled without wake to active");
    wd_kept_a: assert property (RD_CLR_STB && CLK_EN && wq ##1 RD_STB && CLK_EN && wq
        |=> RD_DATA[15:12] == $past(RD_DATA[15:12])) else $error("failure count lost on clear");
    latched_clear_a: assert property (RD_CLR_STB && CLK_EN && !OT_FORCE_EVT && !WD_FORCE_EVT
        && !OT_RETRY_EVT ##1 RD_STB && CLK_EN |=> RD_DATA[11:10] == 2'h0 && RD_DATA[6:4] == 3'h0)
        else $error("latched fields survived clear");
    wd_zero_a: assert property ((WD_OK_EVT || WD_FORCE_EVT) && CLK_EN ##1 tk |=> RD_DATA[15:12] == 4'h0)
        else $error("failure count not zeroed");
    wd_flag_a: assert property (WD_FORCE_EVT && CLK_EN ##1 tk |=> RD_DATA[11])
        else $error("watchdog standby flag not set");
    ot_flag_a: assert property (OT_FORCE_EVT && CLK_EN ##1 tk |=> RD_DATA[10])
        else $error("overheat standby flag not set");
    // Main scenarios reached.
    cover property (tk ##1 tk);
    cover property ($rose(DRV_DISABLE));
    cover property (RD_VALID && RD_DATA[15:12] == 4'hf);
endmodule : psstat_reg_chk

bind psstat_reg psstat_reg_chk #(.SETTLE_CYCLES(SETTLE_CYCLES)) psstat_reg_chk_inst (
    .CORE_CLK(CORE_CLK), .RST_B(RST_B), .CLK_EN(CLK_EN), .RD_STB(RD_STB),
    .RD_CLR_STB(RD_CLR_STB), .WD_FAIL_EVT(WD_FAIL_EVT), .WD_OK_EVT(WD_OK_EVT),
    .WD_FORCE_EVT(WD_FORCE_EVT), .OT_FORCE_EVT(OT_FORCE_EVT), .OT_RETRY_EVT(OT_RETRY_EVT),
    .STATE_CHG_EVT(STATE_CHG_EVT), .NEW_STATE(NEW_STATE), .RD_DATA(RD_DATA),
    .RD_VALID(RD_VALID), .DRV_DISABLE(DRV_DISABLE));

/* File: psstat_reg_bench.sv */
// Purpose: Random self-checking bench for the status register against an integer model.
// Assumes: Settling interval shortened to 20 cycles.
// Notes:   State changes are only issued in cycles without a read; one reset comes mid-run.
module psstat_reg_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SC = 20;
    logic clk = 1'h0, rst_b = 1'h0, en = 1'h1, req_rd = 1'h0, req_clr = 1'h0;
    logic wfa = 1'h0, wok = 1'h0, wfo = 1'h0, ofo = 1'h0, ret = 1'h0, chg = 1'h0;
    logic [1:0] ns = 2'h0;
    logic rd_stb, rd_clr_stb, rd_valid, drv_disable, tk, e;
    logic [15:0] rd_data, expw;
    int seed = 91096, r, error_cnt = 0, cmp_count = 0;
    int wdc, fw, fo, rt, cur, shown, st, dm;
    // Clock of 5 ns period.
    always #2.5 clk = ~clk;
    psstat_host psstat_host_inst (.req_rd(req_rd), .req_clr(req_clr), .rd_stb(rd_stb),
        .rd_clr_stb(rd_clr_stb));
    psstat_reg #(.SETTLE_CYCLES(SC)) psstat_reg_inst (.CORE_CLK(clk), .RST_B(rst_b),
        .CLK_EN(en), .RD_STB(rd_stb), .RD_CLR_STB(rd_clr_stb), .WD_FAIL_EVT(wfa),
        .WD_OK_EVT(wok), .WD_FORCE_EVT(wfo), .OT_FORCE_EVT(ofo), .OT_RETRY_EVT(ret),
        .STATE_CHG_EVT(chg), .NEW_STATE(ns), .RD_DATA(rd_data), .RD_VALID(rd_valid),
        .DRV_DISABLE(drv_disable));
    // Compares one value and counts it.
    task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Prints the counts and the verdict, then stops.
    task complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run
    // Puts the model into the state that the register takes at reset.
    task model_reset;
        wdc = 0;
        fw = 0;
        fo = 0;
        rt = 0;
        cur = 2;
        shown = 2;
        st = 0;
        dm = 1;
        expw = 16'h0;
    endtask : model_reset
    // Random traffic with the model stepped at every taken edge.
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'h1;
        model_reset();
        for (int i = 0; i < 4000; i++) begin
            @(posedge clk);
            e = en && rst_b;
            tk = e && (req_rd || req_clr);
            if (e) begin
                if (tk) begin
                    expw = {wdc[3:0], fw[0], fo[0], shown[1:0], 1'h0, rt[2:0], st > 0, 3'h0};
                    shown = cur;
                end
                dm = st > 0;
                st = (st > 0) ? st - 1 : 0;
                wdc = (wok || wfo) ? 0 : (wfa && wdc < 15) ? wdc + 1 : wdc;
                fw = wfo ? 1 : req_clr ? 0 : fw;
                fo = ofo ? 1 : req_clr ? 0 : fo;
                rt = ret ? (req_clr ? 1 : (rt < 7 ? rt + 1 : 7)) : (req_clr ? 0 : rt);
                if (chg) begin
                    if (cur == 1 && ns == 2'h0) begin
                        st = SC;
                        dm = 1;
                    end
                    shown = (ns == 2'h0 || ns == 2'h3) ? cur : int'(ns);
                    cur = int'(ns);
                end
            end
            r = $random(seed);
            en <= r[31:30] != 2'h0 && i != 2001;  // Quiet edge at the reset release.
            wfa <= r[1:0] != 2'h0;
            wok <= r[9:5] == 5'h0;
            wfo <= r[14:10] == 5'h0;
            ret <= r[17:15] == 3'h0;
            ofo <= r[20:18] == 3'h0;
            req_rd <= r[22:21] == 2'h0;
            req_clr <= r[24:23] == 2'h0;
            chg <= r[27:25] == 3'h0 && r[22:21] != 2'h0 && r[24:23] != 2'h0;
            ns <= r[29:28];
            rst_b <= !(i == 2000 || i == 2001);
            #1;
            // A mid-run reset puts the model back to its reset state.
            if (!rst_b) begin
                model_reset();
                tk = 1'h0;
            end
            if (e) chk("valid", {15'h0, rd_valid}, {15'h0, tk});
            chk("word", rd_data, expw);
            chk("drivers", {15'h0, drv_disable}, {15'h0, dm[0]});
        end
        complete_run();
    end
endmodule : psstat_reg_bench
